// ===== hdl/dcl_top.sv
// command handler for second display line, date/time formats, clock and data logging
// Notes on behaviour
// - second line mode accepts 0 to 9, default 0 (bar graph)
// - decimal limit 0 to 6; fewer shown if resolution short; 6 means maximum
// - external text up to 16 characters, codes 32 to 127 only
// - external text is set only, never read, needs no write enable
// - external text goes to the display only, never saved
// - pressure above the fixed setpoint raises the overpressure indication
// - stored text up to 11 characters, default spaces, kept nonvolatile
// - date order 0 is month/day/year, 1 is day/month/year
// - hour style 0 is twelve hour with am/pm, 1 is 24 hour
// - selected formats govern every date and time value read back
// - clock set not matching current formats is refused, clock unchanged
// - while logging, everything but abort answers busy
// - armed logging starts at start time and ends at stop time
// - arming refused: L1 memory full, L2 start past, L3 stop before start
// - abort stops logging, answers logging off, silent when idle
// - start and stop times written and read in selected formats
// - interval 00:00:00 to 24:59:59, default zero meaning fastest rate
//
// The implementer's own choices: the address map and the APB register port.
module dcl_top #(
  parameter int unsigned TICK_CYCLES = dcl_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] pressure_value,
  input wire logic [31:0] overpressure_setpoint,
  input wire logic [2:0] resolution_places,
  input wire logic sample_strobe,
  input wire logic mem_full,
  output logic [3:0] second_line_mode_select,
  output logic [2:0] decimal_place_limit,
  output logic [127:0] external_line_text,
  output logic [87:0] stored_line_text,
  output logic stored_text_save,
  output logic overpressure_shown,
  output logic logging_active,
  output logic log_record
);
  // ==========================================
  // helpers
  function automatic logic [5:0] days_in(input logic [3:0] mon, input logic [6:0] yr);
    case (mon)
      4'h2: days_in = (yr[1:0] == 2'h0) ? 6'h1d : 6'h1c;
      4'h4, 4'h6, 4'h9, 4'hb: days_in = 6'h1e;
      default: days_in = 6'h1f;
    endcase
  endfunction : days_in

  function automatic dcl_pkg::dcl_time_s tick_time(input dcl_pkg::dcl_time_s t);
    tick_time = t;
    tick_time.sec = t.sec + 6'h01;
    if (8'(t.sec) == dcl_pkg::MINSEC_MAX)
    begin
      tick_time.sec = 6'h00;
      tick_time.min = t.min + 6'h01;
      if (8'(t.min) == dcl_pkg::MINSEC_MAX)
      begin
        tick_time.min = 6'h00;
        tick_time.hour = t.hour + 5'h01;
        if (8'(t.hour) == dcl_pkg::HOUR24_MAX)
        begin
          tick_time.hour = 5'h00;
          tick_time.day = t.day + 5'h01;
          if (6'(t.day) == days_in(t.mon, t.year))
          begin
            tick_time.day = 5'h01;
            tick_time.mon = t.mon + 4'h1;
            if (8'(t.mon) == dcl_pkg::MONTH_MAX)
            begin
              tick_time.mon = 4'h1;
              tick_time.year = (8'(t.year) == dcl_pkg::YEAR_MAX) ? 7'h00 : t.year + 7'h01;
            end
          end
        end
      end
    end
  endfunction : tick_time

  // date word {-, first, second, year}, time word {pm, hour, min, sec}, one byte each
  function automatic logic fmt_ok(input logic [31:0] a0, input logic [31:0] a1, input logic ord,
                                  input logic sty);
    logic [7:0] mon;
    logic [7:0] day;
    logic [7:0] hr;
    mon = ord ? a0[15:8] : a0[23:16];
    day = ord ? a0[23:16] : a0[15:8];
    hr = a1[23:16];
    fmt_ok = (mon != 8'h00) && (mon <= dcl_pkg::MONTH_MAX) && (day != 8'h00) && (day <= dcl_pkg::DAY_MAX)
      && (a0[7:0] <= dcl_pkg::YEAR_MAX) && (a1[15:8] <= dcl_pkg::MINSEC_MAX) && (a1[7:0] <= dcl_pkg::MINSEC_MAX)
      && (sty ? (hr <= dcl_pkg::HOUR24_MAX && !a1[dcl_pkg::PM_BIT]) : (hr != 8'h00 && hr <= dcl_pkg::HOUR12_MAX));
  endfunction : fmt_ok

  function automatic dcl_pkg::dcl_time_s fmt_to_time(input logic [31:0] a0, input logic [31:0] a1,
                                                     input logic ord, input logic sty);
    logic [4:0] h12;
    h12 = (a1[20:16] == 5'h0c) ? 5'h00 : a1[20:16];
    fmt_to_time.year = a0[6:0];
    fmt_to_time.mon = ord ? a0[11:8] : a0[19:16];
    fmt_to_time.day = ord ? a0[20:16] : a0[12:8];
    fmt_to_time.hour = sty ? a1[20:16] : h12 + (a1[dcl_pkg::PM_BIT] ? 5'h0c : 5'h00);
    fmt_to_time.min = a1[13:8];
    fmt_to_time.sec = a1[5:0];
  endfunction : fmt_to_time

  function automatic logic [63:0] time_to_fmt(input dcl_pkg::dcl_time_s t, input logic ord, input logic sty);
    logic [4:0] h12;
    logic pm;
    pm = (8'(t.hour) >= dcl_pkg::HOUR12_MAX);
    h12 = pm ? t.hour - 5'h0c : t.hour;
    if (h12 == 5'h00)
      h12 = 5'h0c;
    time_to_fmt[63:32] = {11'h000, ord ? t.day : 5'(t.mon), 3'h0, ord ? 5'(t.mon) : t.day, 1'b0, t.year};
    time_to_fmt[31:0] = {7'h00, !sty && pm, 3'h0, sty ? t.hour : h12, 2'h0, t.min, 2'h0, t.sec};
  endfunction : time_to_fmt

  function automatic logic text_ok(input logic [15:0] good, input logic [4:0] len, input logic [4:0] max);
    logic [16:0] mask;
    mask = (17'h00001 << len) - 17'h00001;
    text_ok = (len <= max) && ((good | ~mask[15:0]) == 16'hffff);
  endfunction : text_ok

  // ==========================================
  // state
  logic [31:0] arg0_reg;
  logic [31:0] arg1_reg;
  logic [8:0] last_cmd_reg;
  logic [7:0] stage_reg [16];
  logic [3:0] txt_idx_reg;
  logic [15:0] char_good;
  logic [7:0] ext_text_reg [16];
  logic [7:0] stored_text_reg [11];
  logic [3:0] mode_reg;
  logic [2:0] dec_limit_reg;
  logic date_order_reg;
  logic hour_style_reg;
  logic we_armed_reg;
  dcl_pkg::dcl_time_s now_reg;
  dcl_pkg::dcl_time_s start_reg;
  dcl_pkg::dcl_time_s stop_reg;
  logic [23:0] ivl_reg;
  logic [16:0] ivl_secs_reg;
  logic [16:0] ivl_cnt_reg;
  logic [31:0] tick_cnt_reg;
  logic sec_tick;
  logic log_active_reg;
  logic log_armed_reg;
  logic log_prog_reg;
  dcl_pkg::dcl_rsp_e rsp_reg;
  dcl_pkg::dcl_rsp_e rsp_next;
  logic rsp_new_reg;
  logic [31:0] val0_reg;
  logic [31:0] val1_reg;
  logic [31:0] val0_next;
  logic [31:0] val1_next;
  logic [31:0] stat_word;
  logic apply;

  // ==========================================
  // apb access, zero wait states
  logic wr_go;
  logic rd_done;
  logic mapped;
  logic cmd_go;
  logic is_set;
  dcl_pkg::dcl_cmd_e cmd;
  logic [63:0] now_fmt;

  assign pready = 1'b1;
  assign mapped = (paddr <= dcl_pkg::OFS_STAT) && (paddr[1:0] == 2'h0);
  assign pslverr = psel && penable && !mapped;
  assign wr_go = psel && penable && pwrite;
  assign rd_done = psel && penable && !pwrite && paddr == dcl_pkg::OFS_RESP;
  assign cmd_go = wr_go && paddr == dcl_pkg::OFS_CMD;
  assign is_set = pwdata[dcl_pkg::CMD_SET_BIT];
  assign cmd = dcl_pkg::dcl_cmd_e'(pwdata[3:0]);
  assign now_fmt = time_to_fmt(now_reg, date_order_reg, hour_style_reg);
  assign stat_word = {18'h00000, hour_style_reg, date_order_reg, 1'b0, decimal_place_limit, mode_reg,
                      we_armed_reg, overpressure_shown, log_armed_reg, log_active_reg};

  // read data is latched in the setup cycle so it comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        dcl_pkg::OFS_CMD: prdata <= {23'h000000, last_cmd_reg};
        dcl_pkg::OFS_ARG0: prdata <= arg0_reg;
        dcl_pkg::OFS_ARG1: prdata <= arg1_reg;
        dcl_pkg::OFS_TXT: prdata <= (txt_idx_reg < 4'hb) ? {24'h000000, stored_text_reg[txt_idx_reg]} : 32'h00000000;
        dcl_pkg::OFS_RESP: prdata <= {15'h0000, rsp_new_reg, 7'h00, last_cmd_reg[8], last_cmd_reg[3:0], rsp_reg};
        dcl_pkg::OFS_VAL0: prdata <= val0_reg;
        dcl_pkg::OFS_VAL1: prdata <= val1_reg;
        dcl_pkg::OFS_STAT: prdata <= stat_word;
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arg0_reg <= 32'h00000000;
      arg1_reg <= 32'h00000000;
      txt_idx_reg <= 4'h0;
      last_cmd_reg <= 9'h000;
    end
    else
    begin
      if (wr_go && paddr == dcl_pkg::OFS_ARG0)
        arg0_reg <= pwdata;
      if (wr_go && paddr == dcl_pkg::OFS_ARG1)
        arg1_reg <= pwdata;
      if (wr_go && paddr == dcl_pkg::OFS_TXT)
        txt_idx_reg <= pwdata[dcl_pkg::TXT_IDX_LSB +: 4];
      if (cmd_go)
        last_cmd_reg <= pwdata[8:0];
    end
  end

  // ==========================================
  // text staging and character check
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_stage
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          stage_reg[gi] <= dcl_pkg::SPACE;
        else if (wr_go && paddr == dcl_pkg::OFS_TXT && pwdata[dcl_pkg::TXT_IDX_LSB +: 4] == 4'(gi))
          stage_reg[gi] <= pwdata[7:0];
      end
      assign char_good[gi] = stage_reg[gi] >= dcl_pkg::CHAR_MIN && stage_reg[gi] <= dcl_pkg::CHAR_MAX;
      // display-only copy, lost at power off and never written back
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          ext_text_reg[gi] <= dcl_pkg::SPACE;
        else if (cmd_go && cmd == dcl_pkg::CMD_EXT_TEXT && rsp_next == dcl_pkg::RSP_ECHO)
          ext_text_reg[gi] <= (5'(gi) < arg0_reg[4:0]) ? stage_reg[gi] : dcl_pkg::SPACE;
      end
      assign external_line_text[gi*8 +: 8] = ext_text_reg[gi];
      if (gi < 11)
      begin : g_stored
        always_ff @(posedge pclk or negedge presetn)
        begin
          if (!presetn)
            stored_text_reg[gi] <= dcl_pkg::SPACE;
          else if (apply && cmd == dcl_pkg::CMD_STORED_TEXT)
            stored_text_reg[gi] <= (5'(gi) < arg0_reg[4:0]) ? stage_reg[gi] : dcl_pkg::SPACE;
        end
        assign stored_line_text[gi*8 +: 8] = stored_text_reg[gi];
      end
    end
  endgenerate

  // ==========================================
  // command decode
  logic set_valid;
  always_comb
  begin
    set_valid = 1'b0;
    unique case (cmd)
      dcl_pkg::CMD_MODE: set_valid = arg0_reg <= 32'(dcl_pkg::MODE_MAX);
      dcl_pkg::CMD_DECIMALS: set_valid = arg0_reg <= 32'(dcl_pkg::DEC_MAX);
      dcl_pkg::CMD_STORED_TEXT: set_valid = text_ok(char_good, arg0_reg[4:0], dcl_pkg::STORED_LEN);
      dcl_pkg::CMD_DATE_ORDER, dcl_pkg::CMD_HOUR_STYLE: set_valid = arg0_reg <= 32'h00000001;
      dcl_pkg::CMD_CLOCK, dcl_pkg::CMD_LOG_START, dcl_pkg::CMD_LOG_STOP:
        set_valid = fmt_ok(arg0_reg, arg1_reg, date_order_reg, hour_style_reg);
      dcl_pkg::CMD_LOG_INTERVAL:
        set_valid = arg1_reg[31:24] == 8'h00 && arg1_reg[23:16] <= dcl_pkg::IVL_HOUR_MAX
          && arg1_reg[15:8] <= dcl_pkg::MINSEC_MAX && arg1_reg[7:0] <= dcl_pkg::MINSEC_MAX;
      default: set_valid = 1'b0;
    endcase
  end

  always_comb
  begin
    rsp_next = dcl_pkg::RSP_NONE;
    apply = 1'b0;
    if (log_active_reg && cmd != dcl_pkg::CMD_LOG_ABORT)
      rsp_next = dcl_pkg::RSP_BUSY;
    else
    begin
      case (cmd)
        dcl_pkg::CMD_WRITE_ENABLE: rsp_next = dcl_pkg::RSP_NONE;
        dcl_pkg::CMD_LOG_NOW: rsp_next = dcl_pkg::RSP_OK;
        dcl_pkg::CMD_LOG_ARM:
          if (mem_full)
            rsp_next = dcl_pkg::RSP_ERR_L1;
          else if (start_reg < now_reg)
            rsp_next = dcl_pkg::RSP_ERR_L2;
          else if (stop_reg < start_reg)
            rsp_next = dcl_pkg::RSP_ERR_L3;
          else
            rsp_next = dcl_pkg::RSP_OK;
        dcl_pkg::CMD_LOG_ABORT:
          rsp_next = (log_active_reg || log_armed_reg) ? dcl_pkg::RSP_LOG_OFF : dcl_pkg::RSP_NONE;
        dcl_pkg::CMD_EXT_TEXT:
          rsp_next = (is_set && text_ok(char_good, arg0_reg[4:0], dcl_pkg::EXT_LEN)) ? dcl_pkg::RSP_ECHO
                     : dcl_pkg::RSP_REFUSED;
        dcl_pkg::CMD_SETPOINT: rsp_next = is_set ? dcl_pkg::RSP_REFUSED : dcl_pkg::RSP_ECHO;
        default:
          if (!is_set)
            rsp_next = (cmd == dcl_pkg::CMD_STORED_TEXT || 4'(cmd) < 4'hf) ? dcl_pkg::RSP_ECHO
                       : dcl_pkg::RSP_REFUSED;
          else if (!we_armed_reg)
            rsp_next = dcl_pkg::RSP_NONE;
          else if (set_valid)
          begin
            rsp_next = dcl_pkg::RSP_ECHO;
            apply = cmd_go;
          end
          else
            rsp_next = dcl_pkg::RSP_REFUSED;
      endcase
    end
  end

  // echo of a set returns the written words; a read returns current state in current formats, except stored text, which returns its length limit
  always_comb
  begin
    val0_next = arg0_reg;
    val1_next = arg1_reg;
    if (!is_set)
    begin
      val1_next = 32'h00000000;
      case (cmd)
        dcl_pkg::CMD_MODE: val0_next = {28'h0000000, mode_reg};
        dcl_pkg::CMD_DECIMALS: val0_next = {29'h00000000, dec_limit_reg};
        dcl_pkg::CMD_SETPOINT: val0_next = overpressure_setpoint;
        dcl_pkg::CMD_STORED_TEXT: val0_next = 32'(dcl_pkg::STORED_LEN);
        dcl_pkg::CMD_DATE_ORDER: val0_next = {31'h00000000, date_order_reg};
        dcl_pkg::CMD_HOUR_STYLE: val0_next = {31'h00000000, hour_style_reg};
        dcl_pkg::CMD_CLOCK: {val0_next, val1_next} = now_fmt;
        dcl_pkg::CMD_LOG_START: {val0_next, val1_next} = time_to_fmt(start_reg, date_order_reg, hour_style_reg);
        dcl_pkg::CMD_LOG_STOP: {val0_next, val1_next} = time_to_fmt(stop_reg, date_order_reg, hour_style_reg);
        dcl_pkg::CMD_LOG_INTERVAL: val1_next = {8'h00, ivl_reg};
        default: val0_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rsp_reg <= dcl_pkg::RSP_NONE;
      rsp_new_reg <= 1'b0;
      val0_reg <= 32'h00000000;
      val1_reg <= 32'h00000000;
      we_armed_reg <= 1'b0;
    end
    else
    begin
      // a new answer in the cycle of the response read keeps the flag set
      if (cmd_go)
      begin
        rsp_reg <= rsp_next;
        rsp_new_reg <= rsp_next != dcl_pkg::RSP_NONE;
        val0_reg <= val0_next;
        val1_reg <= val1_next;
      end
      else if (rd_done)
        rsp_new_reg <= 1'b0;
      if (cmd_go)
        we_armed_reg <= cmd == dcl_pkg::CMD_WRITE_ENABLE && !log_active_reg;
    end
  end

  // ==========================================
  // display settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg <= dcl_pkg::MODE_RST;
      dec_limit_reg <= dcl_pkg::DEC_RST;
      date_order_reg <= 1'b0;
      hour_style_reg <= 1'b0;
      decimal_place_limit <= dcl_pkg::DEC_RST;
      overpressure_shown <= 1'b0;
      stored_text_save <= 1'b0;
    end
    else
    begin
      if (apply && cmd == dcl_pkg::CMD_MODE)
        mode_reg <= arg0_reg[3:0];
      if (apply && cmd == dcl_pkg::CMD_DECIMALS)
        dec_limit_reg <= arg0_reg[2:0];
      if (apply && cmd == dcl_pkg::CMD_DATE_ORDER)
        date_order_reg <= arg0_reg[0];
      if (apply && cmd == dcl_pkg::CMD_HOUR_STYLE)
        hour_style_reg <= arg0_reg[0];
      decimal_place_limit <= (dec_limit_reg == dcl_pkg::DEC_MAX[2:0] || resolution_places < dec_limit_reg)
                             ? resolution_places : dec_limit_reg;
      overpressure_shown <= pressure_value > overpressure_setpoint;
      // each save costs the nonvolatile store one of its limited write cycles
      stored_text_save <= apply && cmd == dcl_pkg::CMD_STORED_TEXT;
    end
  end
  assign second_line_mode_select = mode_reg;

  // ==========================================
  // clock
  assign sec_tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_reg <= 32'h00000000;
      now_reg <= dcl_pkg::CLOCK_RST;
      start_reg <= dcl_pkg::CLOCK_RST;
      stop_reg <= dcl_pkg::CLOCK_RST;
      ivl_reg <= 24'h000000;
      ivl_secs_reg <= 17'h00000;
    end
    else
    begin
      tick_cnt_reg <= sec_tick ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
      if (apply && cmd == dcl_pkg::CMD_CLOCK)
      begin
        now_reg <= fmt_to_time(arg0_reg, arg1_reg, date_order_reg, hour_style_reg);
        tick_cnt_reg <= 32'h00000000;
      end
      else if (sec_tick)
        now_reg <= tick_time(now_reg);
      if (apply && cmd == dcl_pkg::CMD_LOG_START)
        start_reg <= fmt_to_time(arg0_reg, arg1_reg, date_order_reg, hour_style_reg);
      if (apply && cmd == dcl_pkg::CMD_LOG_STOP)
        stop_reg <= fmt_to_time(arg0_reg, arg1_reg, date_order_reg, hour_style_reg);
      if (apply && cmd == dcl_pkg::CMD_LOG_INTERVAL)
      begin
        ivl_reg <= arg1_reg[23:0];
        ivl_secs_reg <= 17'(32'(arg1_reg[20:16]) * dcl_pkg::SECS_PER_HOUR
                            + 32'(arg1_reg[13:8]) * dcl_pkg::SECS_PER_MIN + 32'(arg1_reg[5:0]));
      end
    end
  end

  // ==========================================
  // logging control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      log_active_reg <= 1'b0;
      log_armed_reg <= 1'b0;
      log_prog_reg <= 1'b0;
      ivl_cnt_reg <= 17'h00000;
      log_record <= 1'b0;
    end
    else
    begin
      log_record <= 1'b0;
      if (cmd_go && cmd == dcl_pkg::CMD_LOG_ABORT)
      begin
        log_active_reg <= 1'b0;
        log_armed_reg <= 1'b0;
        log_prog_reg <= 1'b0;
      end
      else if (cmd_go && rsp_next == dcl_pkg::RSP_OK && cmd == dcl_pkg::CMD_LOG_NOW)
      begin
        log_active_reg <= 1'b1;
        log_prog_reg <= 1'b0;
        ivl_cnt_reg <= 17'h00000;
      end
      else if (cmd_go && rsp_next == dcl_pkg::RSP_OK && cmd == dcl_pkg::CMD_LOG_ARM)
        log_armed_reg <= 1'b1;
      else if (log_armed_reg && now_reg >= start_reg)
      begin
        log_armed_reg <= 1'b0;
        log_active_reg <= 1'b1;
        log_prog_reg <= 1'b1;
        ivl_cnt_reg <= 17'h00000;
      end
      else if (log_active_reg && log_prog_reg && now_reg >= stop_reg)
      begin
        log_active_reg <= 1'b0;
        log_prog_reg <= 1'b0;
      end
      else if (log_active_reg)
      begin
        if (ivl_secs_reg == 17'h00000)
          log_record <= sample_strobe;
        else if (sec_tick)
        begin
          ivl_cnt_reg <= (ivl_cnt_reg + 17'h00001 == ivl_secs_reg) ? 17'h00000 : ivl_cnt_reg + 17'h00001;
          log_record <= ivl_cnt_reg + 17'h00001 == ivl_secs_reg;
        end
      end
    end
  end
  assign logging_active = log_active_reg;
endmodule : dcl_top

// ===== hdl/dcl_pkg.sv
// shared constants and types for the display, clock and logging command handler
package dcl_pkg;
  // ==========================================
  // timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_PERIOD_MS = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int unsigned SECS_PER_HOUR = 3600;
  localparam int unsigned SECS_PER_MIN = 60;

  // ==========================================
  // register offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ARG0 = 8'h04;
  localparam logic [7:0] OFS_ARG1 = 8'h08;
  localparam logic [7:0] OFS_TXT = 8'h0c;
  localparam logic [7:0] OFS_RESP = 8'h10;
  localparam logic [7:0] OFS_VAL0 = 8'h14;
  localparam logic [7:0] OFS_VAL1 = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1c;

  // ==========================================
  // field positions
  localparam int CMD_SET_BIT = 8;
  localparam int RESP_NEW_BIT = 16;
  localparam int TXT_IDX_LSB = 8;
  localparam int PM_BIT = 24;

  // ==========================================
  // limits and reset values
  localparam logic [7:0] MODE_MAX = 8'h09;
  localparam logic [7:0] DEC_MAX = 8'h06;
  localparam logic [4:0] EXT_LEN = 5'h10;
  localparam logic [4:0] STORED_LEN = 5'h0b;
  localparam logic [7:0] CHAR_MIN = 8'h20;
  localparam logic [7:0] CHAR_MAX = 8'h7f;
  localparam logic [7:0] SPACE = 8'h20;
  localparam logic [7:0] YEAR_MAX = 8'h63;
  localparam logic [7:0] MONTH_MAX = 8'h0c;
  localparam logic [7:0] DAY_MAX = 8'h1f;
  localparam logic [7:0] HOUR24_MAX = 8'h17;
  localparam logic [7:0] HOUR12_MAX = 8'h0c;
  localparam logic [7:0] IVL_HOUR_MAX = 8'h18;
  localparam logic [7:0] MINSEC_MAX = 8'h3b;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [2:0] DEC_RST = 3'h6;

  typedef enum logic [3:0] {
    CMD_MODE, CMD_DECIMALS, CMD_EXT_TEXT, CMD_SETPOINT, CMD_STORED_TEXT,
    CMD_DATE_ORDER, CMD_HOUR_STYLE, CMD_CLOCK, CMD_LOG_NOW, CMD_LOG_ARM,
    CMD_LOG_ABORT, CMD_LOG_START, CMD_LOG_STOP, CMD_LOG_INTERVAL, CMD_WRITE_ENABLE
  } dcl_cmd_e;

  typedef enum logic [3:0] {
    RSP_NONE, RSP_ECHO, RSP_OK, RSP_ERR_L1, RSP_ERR_L2, RSP_ERR_L3,
    RSP_BUSY, RSP_LOG_OFF, RSP_REFUSED
  } dcl_rsp_e;

  // field order makes the packed value compare as time order
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] mon;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } dcl_time_s;

  localparam dcl_time_s CLOCK_RST = '{year: 7'h00, mon: 4'h1, day: 5'h01, hour: 5'h00, min: 6'h00, sec: 6'h00};
endpackage : dcl_pkg

// ===== verif/dcl_top_props.sv
// port checker for the command handler
module dcl_top_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] pressure_value,
  input wire logic [31:0] overpressure_setpoint,
  input wire logic [2:0] resolution_places,
  input wire logic [3:0] second_line_mode_select,
  input wire logic [2:0] decimal_place_limit,
  input wire logic stored_text_save,
  input wire logic overpressure_shown,
  input wire logic logging_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cw;
  assign cw = psel && penable && pwrite && paddr == 8'h00;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("ready");
  a_err_map: assert property (psel && penable |-> pslverr == (paddr > 8'h1c || paddr[1:0] != 2'h0)) else $error("err");
  a_mode_range: assert property (second_line_mode_select <= 4'h9) else $error("mode");
  a_dec_cap: assert property ($past(presetn) |-> decimal_place_limit <= $past(resolution_places))
    else $error("dec");
  a_over_show: assert property (pressure_value > overpressure_setpoint |=> overpressure_shown) else $error("ovr");
  a_abort_stop: assert property (cw && pwdata[3:0] == 4'ha |=> !logging_active) else $error("abort");
  a_busy_hold: assert property (logging_active && cw && pwdata[3:0] != 4'ha |=> $stable(second_line_mode_select))
    else $error("busy");
  a_save_pulse: assert property (stored_text_save |=> !stored_text_save) else $error("save");
endmodule : dcl_top_props

// ===== verif/dcl_sensor.sv
// sensor side model: one sample pulse every fourth clock
module dcl_sensor (
  input wire logic clk,
  input wire logic rst_n,
  output logic strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_reg;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) cnt_reg <= 2'h0;
    else cnt_reg <= cnt_reg + 2'h1;
  assign strobe = cnt_reg == 2'h3;
endmodule : dcl_sensor

// ===== verif/dcl_top_test.sv
// bench for the command handler
module dcl_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, stb, mfull = 0, ovr, act;
  logic sav, lrec;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, pv = 32'h0;
  logic [3:0] mode;
  logic [2:0] dec;
  logic [127:0] ext;
  logic [87:0] sto;
  int n_fail = 0, compares = 0, cyc = 0, saves = 0, recs = 0;
  always #20 pclk = ~pclk;
  dcl_sensor sen_u (.clk(pclk), .rst_n(presetn), .strobe(stb));
  dcl_top #(.TICK_CYCLES(10)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pressure_value(pv), .overpressure_setpoint(32'h64), .resolution_places(3'h4), .sample_strobe(stb),
    .mem_full(mfull), .second_line_mode_select(mode), .decimal_place_limit(dec), .external_line_text(ext),
    .stored_line_text(sto), .stored_text_save(sav), .overpressure_shown(ovr), .logging_active(act),
    .log_record(lrec));
  task automatic close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  always @(posedge pclk)
  begin
    if (sav) saves++;
    if (lrec) recs++;
    cyc++;
    if (cyc == 2000) n_fail++;
    if (cyc == 2000) close_out();
  end
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xf
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) n_fail++;
    if (s !== e) $display("[ERR] %0t seen %h want %h", $time, s, e);
  endtask : chk
  // kind nibble only: the new flag after an ignored command is left open
  task automatic cmd(input logic [31:0] c, input logic [3:0] k);
    xf(1'b1, 8'h00, c);
    xf(1'b0, 8'h10, 32'h0);
    chk(32'(r[3:0]), 32'(k));
  endtask : cmd
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    xf(1'b0, 8'h1c, 32'h0);
    chk(r, 32'h400);
    xf(1'b0, 8'h40, 32'h0);
    xf(1'b1, 8'h04, 32'h9);
    cmd(32'h100, 4'h0);
    xf(1'b1, 8'h00, 32'he);
    cmd(32'h100, 4'h1);
    chk(32'(mode), 32'h9);
    xf(1'b1, 8'h04, 32'ha);
    xf(1'b1, 8'h00, 32'he);
    cmd(32'h100, 4'h8);
    xf(1'b1, 8'h00, 32'he);
    cmd(32'h101, 4'h8);
    xf(1'b1, 8'h04, 32'h2);
    xf(1'b1, 8'h00, 32'he);
    cmd(32'h101, 4'h1);
    chk(32'(dec), 32'h2);
    xf(1'b1, 8'h04, 32'h1);
    xf(1'b1, 8'h0c, 32'h41);
    cmd(32'h102, 4'h1);
    chk(32'(ext[15:0]), 32'h2041);
    cmd(32'h002, 4'h8);
    xf(1'b1, 8'h0c, 32'h42);
    xf(1'b1, 8'h00, 32'he);
    cmd(32'h104, 4'h1);
    chk(32'(sto[15:0]), 32'h2042);
    xf(1'b1, 8'h00, 32'he);
    xf(1'b1, 8'h04, 32'hd0100);
    cmd(32'h107, 4'h8);
    cmd(32'h007, 4'h1);
    xf(1'b0, 8'h14, 32'h0);
    chk(r, 32'h10100);
    mfull <= 1'b1;
    cmd(32'h009, 4'h3);
    mfull <= 1'b0;
    pv <= 32'hc8;
    cmd(32'h008, 4'h2);
    chk(32'(act), 32'h1);
    chk(32'(ovr), 32'h1);
    cmd(32'h100, 4'h6);
    cmd(32'h00a, 4'h7);
    chk(32'(act), 32'h0);
    cmd(32'h00a, 4'h0);
    // 10:00:00 am on 01/02/05, then arm for 10:00:20 to 10:00:59
    xf(1'b1, 8'h04, 32'h10205);
    xf(1'b1, 8'h08, 32'ha0000);
    xf(1'b1, 8'h00, 32'he);
    cmd(32'h107, 4'h1);
    cmd(32'h007, 4'h1);
    xf(1'b0, 8'h14, 32'h0);
    chk(r, 32'h10205);
    xf(1'b0, 8'h18, 32'h0);
    chk(r, 32'ha0000);
    xf(1'b1, 8'h08, 32'ha0014);
    xf(1'b1, 8'h00, 32'he);
    cmd(32'h10b, 4'h1);
    xf(1'b1, 8'h08, 32'ha003b);
    xf(1'b1, 8'h00, 32'he);
    cmd(32'h10c, 4'h1);
    cmd(32'h009, 4'h2);
    repeat (200) @(posedge pclk);
    chk(32'(act), 32'h1);
    cmd(32'h00a, 4'h7);
    chk(32'(recs != 0), 32'h1);
    chk(saves, 32'h1);
    close_out();
  end
endmodule : dcl_top_test
bind dcl_top dcl_top_props chk_u (.*);
